//--- common/apo_pkg.sv
// Purpose: shared constants and types of the converter output port
// Assumes: converter clock is the block clock
// Notes:   codes are offset binary, low line is the least significant bit
package apo_pkg;
  localparam int CODE_W        = 12;
  localparam int STAGE_COUNT   = 12;
  localparam int BITS_PER_CLK  = 2;
  localparam int CLK_STAGES    = STAGE_COUNT / BITS_PER_CLK;
  localparam int LATENCY_CLK   = 7;
  localparam int SYNC_DEPTH    = 3;
  localparam int CLK_HZ        = 20_000_000;
  localparam int CLK_MIN_HZ    = 100_000;
  localparam int CLK_MAX_HZ    = 40_000_000;
  localparam int FILL_W        = 3;
  localparam logic [FILL_W-1:0] FILL_DONE  = 3'h7;
  localparam logic [FILL_W-1:0] FILL_RESET = 3'h0;
  localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
  localparam logic [CODE_W-1:0] CODE_ZERO  = 12'h800;
  localparam int SIGN_BIT      = CODE_W - 1;

  typedef enum logic [0:0] {
    APO_RUN,
    APO_SHUTDOWN
  } apo_state_t;
endpackage

//--- src/apo_port.sv
// Purpose: digital side of a 12-bit pipelined converter, from sample to parallel code pins
// Assumes: clock_i is the true converter clock; samples arrive as signed step counts
// Notes:   output drive and shutdown pins pass a three-flop filter before use
// Function
// - Code appears seven clocks after sampling
// - Sample taken on true clock rising edge
// - Enable high releases all twelve outputs
// - Shutdown request stops new conversion results
// - Shutdown holds last driven code unchanged
// - Bit zero least significant, bit eleven most
// - Offset binary, 2048 steps per polarity
// - Twelve one-bit stages, uncorrected merge
// - Zero 800, minus one 7ff, minimum 000
`timescale 1ns/10ps
`default_nettype none
module apo_port (
  input  wire logic                        clock_i,
  input  wire logic                        rst_i,
  input  wire logic [apo_pkg::CODE_W-1:0]  analog_sample_i,
  input  wire logic                        output_drive_n_i,
  input  wire logic                        power_off_request_i,
  output logic      [apo_pkg::CODE_W-1:0]  sample_code_bus_o,
  output logic                             sample_code_bus_oe_o,
  output logic                             code_valid_o
);

  // Signed step count to offset binary by flipping the sign
  function automatic logic [apo_pkg::CODE_W-1:0] to_offset(input logic [apo_pkg::CODE_W-1:0] s);
    to_offset = {~s[apo_pkg::SIGN_BIT], s[apo_pkg::SIGN_BIT-1:0]};
  endfunction

  // Two one-bit stages per clock: move the top bits of the residue into the code
  function automatic logic [apo_pkg::CODE_W-1:0] stage_code(input logic [apo_pkg::CODE_W-1:0] code,
                                                            input logic [apo_pkg::CODE_W-1:0] res);
    stage_code = {code[apo_pkg::CODE_W-apo_pkg::BITS_PER_CLK-1:0],
                  res[apo_pkg::CODE_W-1:apo_pkg::CODE_W-apo_pkg::BITS_PER_CLK]};
  endfunction

  logic [apo_pkg::SYNC_DEPTH-1:0]  oe_sync_reg;
  logic [apo_pkg::SYNC_DEPTH-1:0]  oe_sync_next;
  logic [apo_pkg::SYNC_DEPTH-1:0]  pd_sync_reg;
  logic [apo_pkg::SYNC_DEPTH-1:0]  pd_sync_next;
  logic                            oe_n_reg;
  logic                            oe_n_next;
  logic                            pd_reg;
  logic                            pd_next;

  apo_pkg::apo_state_t             state_reg;
  apo_pkg::apo_state_t             state_next;
  logic [apo_pkg::CODE_W-1:0]      sample_reg;
  logic [apo_pkg::CODE_W-1:0]      sample_next;
  logic [apo_pkg::CODE_W-1:0]      res_reg  [apo_pkg::CLK_STAGES];
  logic [apo_pkg::CODE_W-1:0]      res_next [apo_pkg::CLK_STAGES];
  logic [apo_pkg::CODE_W-1:0]      code_reg [apo_pkg::CLK_STAGES];
  logic [apo_pkg::CODE_W-1:0]      code_next[apo_pkg::CLK_STAGES];
  logic [apo_pkg::CODE_W-1:0]      out_reg;
  logic [apo_pkg::CODE_W-1:0]      out_next;
  logic                            drive_reg;
  logic                            drive_next;
  logic                            valid_reg;
  logic                            valid_next;
  logic [apo_pkg::FILL_W-1:0]      fill_reg;
  logic [apo_pkg::FILL_W-1:0]      fill_next;
  logic                            run_now;

  // Enable pin filter: a change counts once the second and third flops agree
  always_comb begin
    oe_sync_next = {oe_sync_reg[apo_pkg::SYNC_DEPTH-2:0], output_drive_n_i};
    oe_n_next    = oe_n_reg;
    if (oe_sync_reg[1] == oe_sync_reg[2]) begin
      oe_n_next = oe_sync_reg[2];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      oe_sync_reg <= '1;
      oe_n_reg    <= 1'b1;
    end else begin
      oe_sync_reg <= oe_sync_next;
      oe_n_reg    <= oe_n_next;
    end
  end

  // Shutdown pin filter, same agreement rule
  always_comb begin
    pd_sync_next = {pd_sync_reg[apo_pkg::SYNC_DEPTH-2:0], power_off_request_i};
    pd_next      = pd_reg;
    if (pd_sync_reg[1] == pd_sync_reg[2]) begin
      pd_next = pd_sync_reg[2];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pd_sync_reg <= '0;
      pd_reg      <= 1'b0;
    end else begin
      pd_sync_reg <= pd_sync_next;
      pd_reg      <= pd_next;
    end
  end

  // Shutdown control
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      apo_pkg::APO_RUN: begin
        if (pd_reg) begin
          state_next = apo_pkg::APO_SHUTDOWN;
        end
      end
      apo_pkg::APO_SHUTDOWN: begin
        if (!pd_reg) begin
          state_next = apo_pkg::APO_RUN;
        end
      end
      default: begin
        state_next = apo_pkg::APO_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= apo_pkg::APO_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // The pipeline advances only while running and no shutdown is pending
  assign run_now = (state_reg == apo_pkg::APO_RUN) && !pd_reg;

  // Conversion pipeline and output latch
  always_comb begin
    sample_next = sample_reg;
    out_next    = out_reg;
    for (int i = 0; i < apo_pkg::CLK_STAGES; i++) begin
      res_next[i]  = res_reg[i];
      code_next[i] = code_reg[i];
    end
    if (run_now) begin
      sample_next = to_offset(analog_sample_i);
      res_next[0]  = sample_reg << apo_pkg::BITS_PER_CLK;
      code_next[0] = stage_code(apo_pkg::CODE_RESET, sample_reg);
      for (int i = 1; i < apo_pkg::CLK_STAGES; i++) begin
        res_next[i]  = res_reg[i-1] << apo_pkg::BITS_PER_CLK;
        code_next[i] = stage_code(code_reg[i-1], res_reg[i-1]);
      end
      out_next = code_reg[apo_pkg::CLK_STAGES-1];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sample_reg <= apo_pkg::CODE_ZERO;
      for (int i = 0; i < apo_pkg::CLK_STAGES; i++) begin
        res_reg[i]  <= apo_pkg::CODE_RESET;
        code_reg[i] <= apo_pkg::CODE_RESET;
      end
      out_reg <= apo_pkg::CODE_RESET;
    end else begin
      sample_reg <= sample_next;
      for (int i = 0; i < apo_pkg::CLK_STAGES; i++) begin
        res_reg[i]  <= res_next[i];
        code_reg[i] <= code_next[i];
      end
      out_reg <= out_next;
    end
  end

  // Refill counter; stale codes stay flagged invalid until fresh samples arrive
  always_comb begin
    fill_next  = apo_pkg::FILL_RESET;
    valid_next = 1'b0;
    if (run_now) begin
      if (fill_reg == apo_pkg::FILL_DONE) begin
        fill_next  = fill_reg;
        valid_next = 1'b1;
      end else begin
        fill_next = fill_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      valid_reg <= 1'b0;
      fill_reg  <= apo_pkg::FILL_RESET;
    end else begin
      valid_reg <= valid_next;
      fill_reg  <= fill_next;
    end
  end

  // Output drive flag
  always_comb begin
    drive_next = ~oe_n_reg;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign sample_code_bus_o    = out_reg;
  assign sample_code_bus_oe_o = drive_reg;
  assign code_valid_o         = valid_reg;

endmodule
`default_nettype wire

//--- verification/apo_capture.sv
// Purpose: capture side
// Assumes: none
// Notes:   released bus inverted
`timescale 1ns/10ps
`default_nettype none
module apo_capture (
  input  wire logic [11:0] code_i,
  input  wire logic        oe_i,
  output logic      [11:0] bus_o
);
  assign bus_o = oe_i ? code_i : ~code_i;
endmodule
`default_nettype wire

//--- verification/apo_port_monitor.sv
// Purpose: code port checker
// Assumes: one clock
// Notes:   bound to apo_port
`timescale 1ns/10ps
`default_nettype none
module apo_port_monitor (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic [11:0] analog_sample_i,
  input wire logic        output_drive_n_i,
  input wire logic        power_off_request_i,
  input wire logic [11:0] sample_code_bus_o,
  input wire logic        sample_code_bus_oe_o,
  input wire logic        code_valid_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire sd = power_off_request_i;
  sequence refill_s; (!code_valid_o) [*8] ##[1:10] code_valid_o; endsequence
  // Counts earlier consecutive cycles of valid running output
  logic [3:0] run_cnt;
  always_ff @(posedge clock_i) begin
    if (rst_i) run_cnt <= 4'h0;
    else if (!(code_valid_o && !sd)) run_cnt <= 4'h0;
    else if (run_cnt != 4'hf) run_cnt <= run_cnt + 4'h1;
  end
  a_code_latency: assert property (code_valid_o && !sd && run_cnt >= 4'h8
    |-> sample_code_bus_o == ($past(analog_sample_i, 8) ^ 12'h800)) else $error("latency");
  a_oe_off: assert property (output_drive_n_i [*6] |-> !sample_code_bus_oe_o) else $error("oe on");
  a_oe_on: assert property ((!output_drive_n_i) [*6] |-> sample_code_bus_oe_o) else $error("oe off");
  a_code_freeze: assert property (sd [*8] |-> $stable(sample_code_bus_o)) else $error("moved");
  a_off_invalid: assert property (sd [*8] |-> !code_valid_o) else $error("valid");
  a_exit_refill: assert property (sd [*7] ##1 !sd |-> refill_s) else $error("exit");
  a_reset_out: assert property ($fell(rst_i) |-> sample_code_bus_o == 12'h000) else $error("rst");
  a_reset_fill: assert property ($fell(rst_i) |-> refill_s) else $error("fill");
endmodule
bind apo_port apo_port_monitor u_mon (.*);
`default_nettype wire

//--- verification/test_apo_port.sv
// Purpose: code port bench
// Assumes: falling-edge drive
// Notes:   fixed waits
`timescale 1ns/10ps
`default_nettype none
module test_apo_port;
  logic        clock_i = 1'b0, rst_i = 1'b1, output_drive_n_i = 1'b0, power_off_request_i = 1'b0, oe;
  logic [11:0] analog_sample_i = 12'h000, code, bus;
  logic        valid;
  int          num_errors = 0, compares = 0;
  always #25 clock_i = ~clock_i;
  apo_port DUT (.clock_i, .rst_i, .analog_sample_i, .output_drive_n_i, .power_off_request_i,
    .sample_code_bus_o(code), .sample_code_bus_oe_o(oe), .code_valid_o(valid));
  apo_capture cap (.code_i(code), .oe_i(oe), .bus_o(bus));
  task automatic cyc(int n); repeat (n) @(negedge clock_i); endtask
  task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
    compares++;
    num_errors += int'(seen !== exp);
    if (seen !== exp) $display("ERROR %s expected %h seen %h", name, exp, seen);
  endtask
  task automatic report_and_stop(int late);
    num_errors += late;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_stream();
    logic [23:0] t [7] = '{24'h800000, 24'h801001, 24'hfff7ff, 24'h000800, 24'h001801, 24'h7feffe, 24'h7fffff};
    for (int i = 0; i < 15; i++) begin
      if (i < 7) analog_sample_i = t[i][23:12];
      if (i > 7) check("code", bus, t[i-8][11:0]);
      cyc(1);
    end
  endtask
  task automatic t_pins();
    output_drive_n_i = 1'b1;
    cyc(6);
    check("oe", 12'(oe), 12'h000);
    output_drive_n_i = 1'b0;
    power_off_request_i = 1'b1;
    analog_sample_i = 12'h456;
    cyc(12);
    check("frozen", bus, 12'hfff);
    check("off valid", 12'(valid), 12'h000);
    power_off_request_i = 1'b0;
    cyc(20);
    check("fresh", bus, 12'hc56);
    check("valid", 12'(valid), 12'h001);
  endtask
  initial begin
    cyc(20);
    rst_i = 1'b0;
    t_stream();
    t_pins();
    report_and_stop(0);
  end
  initial #100us report_and_stop(1);
endmodule
`default_nettype wire
